// File: core/dss_pkg.sv
// Constants, types and register map of the drive safety and select logic.
package dss_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ         = 10;
  localparam int DEBOUNCE_US     = 10000;
  localparam int DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
  localparam int SETTLE_US       = 2;
  localparam int SETTLE_CYC      = SETTLE_US * CLK_MHZ;
  localparam int DEB_W           = 17;
  localparam int SET_W           = 5;

  // ****************************************
  // Bus and units
  // ****************************************
  localparam int NUM_UNITS       = 4;
  localparam int UNIT_W          = 2;
  localparam logic [1:0] UNIT_ONE = 2'h0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam int CTRL_TOP_LOAD      = 0;
  localparam int CTRL_SEL_FITTED    = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int STATUS_W           = 11;

  // ****************************************
  // Raw panel inputs
  // ****************************************
  localparam int RAW_W        = 4;
  localparam int RAW_RUN_KEY  = 0;
  localparam int RAW_GUARD_RM = 1;
  localparam int RAW_GUARD_FX = 2;
  localparam int RAW_CART_OK  = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    DSS_IDLE = 2'b00,
    DSS_RUN  = 2'b01,
    DSS_STOP = 2'b10
  } dss_run_t;

  typedef struct packed {
    logic power_ok;
    logic disk_stopped;
    logic heads_retracted;
    logic brake_active;
    logic brushes_home;
    logic speed_checked;
    logic speed_ok;
    logic positioner_err;
    logic write_fault;
    logic write_active;
  } dss_sense_t;

  typedef struct packed {
    logic head_unload;
    logic cart_ok;
    logic guard_fixed;
    logic guard_removable;
    logic bus_settled;
    logic selected;
    logic inhibit;
    logic emergency;
    logic stopping;
    logic run;
    logic safe;
  } dss_status_t;

endpackage

// File: core/dss_top.sv
// Safe state, run/stop control, write guard and unit selection of a cartridge drive.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dss_top
  import dss_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYC
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [RAW_W-1:0]   panel_raw,
  input  wire dss_sense_t         sense,
  input  wire logic [UNIT_W-1:0]  unit_dial,
  input  wire logic [NUM_UNITS-1:0] unit_select_n,
  input  wire logic               start_stop_n,
  input  wire logic               write_protect_in_n,
  input  wire logic               platter_select_n,
  output logic                    safe_lamp,
  output logic                    cart_lock,
  output logic                    run_lamp,
  output logic                    spin_enable,
  output logic                    emergency_unload,
  output logic                    head_unload,
  output logic                    write_guard_lamp_upper,
  output logic                    write_guard_lamp_lower,
  output logic                    write_allow,
  output logic                    platter_fixed,
  output logic                    bus_settled,
  output logic                    write_protect_out_n_o,
  output logic                    write_protect_out_oe
);

  // ****************************************
  // Helper functions
  // ****************************************
  // Selects which unit line this drive answers.
  function automatic logic [UNIT_W-1:0] unit_of(input logic fitted,
                                                input logic [UNIT_W-1:0] dial);
    unit_of = fitted ? dial : UNIT_ONE;
  endfunction

  // ****************************************
  // Registers and declarations
  // ****************************************
  logic [1:0]              ctrl;
  logic [RAW_W-1:0]        sync1;
  logic [RAW_W-1:0]        sync2;
  logic [RAW_W-1:0]        stable;
  logic [DEB_W-1:0]        deb_cnt [RAW_W];
  logic                    key_prev;
  logic                    key_press;
  dss_run_t                run_st;
  dss_run_t                next_run_st;
  logic                    fault;
  logic                    inhibit;
  logic                    safe_now;
  logic                    guard_rm;
  logic                    guard_fx;
  logic                    selected;
  logic [SET_W-1:0]        settle_cnt;
  logic                    wp_in;
  logic                    aw_got;
  logic                    w_got;
  logic [3:0]              aw_off;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  dss_status_t             status;

  // ****************************************
  // Input conditioning
  // ****************************************
  // Two-stage synchroniser on the raw panel inputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= panel_raw;
      sync2 <= sync1;
    end
  end

  // Debouncer: a new level is accepted after it holds for the full count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable <= '0;
      for (int i = 0; i < RAW_W; i++) begin
        deb_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < RAW_W; i++) begin
        if (sync2[i] == stable[i]) begin
          deb_cnt[i] <= '0;
        end else if (deb_cnt[i] >= DEB_W'(DEB_CYCLES - 1)) begin
          stable[i]  <= sync2[i];
          deb_cnt[i] <= '0;
        end else begin
          deb_cnt[i] <= deb_cnt[i] + 1'b1;
        end
      end
    end
  end

  // Key press edge detector on the debounced key.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_prev <= 1'b0;
    end else begin
      key_prev <= stable[RAW_RUN_KEY];
    end
  end

  assign key_press = stable[RAW_RUN_KEY] & ~key_prev;

  // ****************************************
  // Fault, inhibit and safe conditions
  // ****************************************
  assign fault = ~sense.power_ok | (sense.speed_checked & ~sense.speed_ok)
               | sense.positioner_err | sense.write_fault;

  assign inhibit = ~stable[RAW_CART_OK] | ~sense.power_ok | fault;

  assign safe_now = sense.power_ok & sense.disk_stopped & sense.heads_retracted
                  & ~fault & ~sense.brake_active & (run_st != DSS_STOP)
                  & (~ctrl[CTRL_TOP_LOAD] | sense.brushes_home);

  // Safe lamp and cartridge lock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safe_lamp <= 1'b0;
      cart_lock <= 1'b1;
    end else begin
      safe_lamp <= safe_now;
      cart_lock <= ~safe_now;
    end
  end

  // ****************************************
  // Run state machine
  // ****************************************
  always_comb begin
    next_run_st = run_st;
    unique case (run_st)
      DSS_IDLE: begin
        if (key_press && !inhibit) begin
          next_run_st = DSS_RUN;
        end
      end
      DSS_RUN: begin
        if (key_press) begin
          next_run_st = DSS_STOP;
        end
      end
      DSS_STOP: begin
        if (sense.disk_stopped && sense.heads_retracted) begin
          next_run_st = DSS_IDLE;
        end
      end
      default: begin
        next_run_st = DSS_IDLE;
      end
    endcase
    if (fault) begin
      next_run_st = DSS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_st <= DSS_IDLE;
    end else begin
      run_st <= next_run_st;
    end
  end

  // Lamps, spindle and head control.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_lamp         <= 1'b0;
      spin_enable      <= 1'b0;
      emergency_unload <= 1'b0;
      head_unload      <= 1'b0;
    end else begin
      run_lamp         <= (next_run_st == DSS_RUN) & ~inhibit;
      spin_enable      <= (next_run_st == DSS_RUN) & ~inhibit & ~start_stop_n;
      emergency_unload <= fault;
      head_unload      <= fault
                        | ((run_st == DSS_STOP) & ~sense.write_active);
    end
  end

  // ****************************************
  // Write guard
  // ****************************************
  // Protection status follows the switches except during write or erase.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_rm <= 1'b1;
      guard_fx <= 1'b1;
    end else if (!sense.write_active) begin
      guard_rm <= stable[RAW_GUARD_RM];
      guard_fx <= stable[RAW_GUARD_FX];
    end
  end

  assign write_guard_lamp_upper = guard_rm;
  assign write_guard_lamp_lower = guard_fx;

  // ****************************************
  // Unit selection and bus gating
  // ****************************************
  assign selected = ~unit_select_n[unit_of(ctrl[CTRL_SEL_FITTED], unit_dial)];

  // Settling counter restarts on every new selection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt  <= '0;
      bus_settled <= 1'b0;
    end else if (!selected) begin
      settle_cnt  <= '0;
      bus_settled <= 1'b0;
    end else if (settle_cnt < SET_W'(SETTLE_CYC - 1)) begin
      settle_cnt <= settle_cnt + 1'b1;
    end else begin
      bus_settled <= 1'b1;
    end
  end

  assign wp_in = selected & ~write_protect_in_n;

  // Gated interface inputs and outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      platter_fixed         <= 1'b0;
      write_allow           <= 1'b0;
      write_protect_out_n_o <= 1'b1;
      write_protect_out_oe  <= 1'b0;
    end else begin
      platter_fixed <= selected ? ~platter_select_n : platter_fixed;
      write_allow   <= selected & ~wp_in
                     & ~(platter_fixed ? guard_fx : guard_rm);
      write_protect_out_n_o <= ~(platter_fixed ? guard_fx : guard_rm);
      write_protect_out_oe  <= selected & bus_settled;
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  assign status = '{
    head_unload:     head_unload,
    cart_ok:         stable[RAW_CART_OK],
    guard_fixed:     guard_fx,
    guard_removable: guard_rm,
    bus_settled:     bus_settled,
    selected:        selected,
    inhibit:         inhibit,
    emergency:       emergency_unload,
    stopping:        run_st == DSS_STOP,
    run:             run_st == DSS_RUN,
    safe:            safe_lamp
  };

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_off <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      aw_off <= s_axi_awaddr[3:0];
    end else if (aw_got && w_got) begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got  <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got  <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (aw_got && w_got) begin
      w_got <= 1'b0;
    end
  end

  // Register update and write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl         <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_got && w_got) begin
      s_axi_bvalid <= 1'b1;
      if (aw_off == OFF_CTRL) begin
        s_axi_bresp <= RESP_OKAY;
        if (w_strb[0]) begin
          ctrl <= w_data[1:0];
        end
      end else if (aw_off == OFF_STATUS) begin
        s_axi_bresp <= RESP_SLVERR;
      end else begin
        s_axi_bresp <= RESP_DECERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr[3:0] == OFF_CTRL) begin
        s_axi_rdata[1:0] <= ctrl;
      end else if (s_axi_araddr[3:0] == OFF_STATUS) begin
        s_axi_rdata[STATUS_W-1:0] <= status;
      end else begin
        s_axi_rresp <= RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dss_top
`default_nettype wire

// File: bench/dss_checker.sv
// Concurrent checks on the ports of the drive safety and select logic.
`timescale 1ns/1ps
`default_nettype none
module dss_checker
  import dss_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire dss_sense_t           sense,
  input  wire logic [NUM_UNITS-1:0] unit_select_n,
  input  wire logic                 start_stop_n,
  input  wire logic                 write_protect_in_n,
  input  wire logic                 safe_lamp,
  input  wire logic                 cart_lock,
  input  wire logic                 run_lamp,
  input  wire logic                 spin_enable,
  input  wire logic                 emergency_unload,
  input  wire logic                 head_unload,
  input  wire logic                 write_allow,
  input  wire logic                 bus_settled,
  input  wire logic                 write_protect_out_oe
);
  int unsigned sel_cnt;
  // ****************************************
  // Selection length counter
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || &unit_select_n || $changed(unit_select_n)) begin
      sel_cnt <= 0;
    end else if (sel_cnt < 30) begin
      sel_cnt <= sel_cnt + 1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_fault;
    !sense.power_ok || (sense.speed_checked && !sense.speed_ok) ||
      sense.positioner_err || sense.write_fault;
  endsequence
  sequence s_unload;
    ##[0:1] head_unload;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_fault_unload: assert property (s_fault |=> emergency_unload)
    else $error("fault without emergency unload");
  a_unload_heads: assert property (emergency_unload |-> s_unload)
    else $error("emergency without head unload");
  a_emerg_dark: assert property (emergency_unload |=> !run_lamp)
    else $error("run lamp lit in emergency");
  a_spin_run: assert property (spin_enable |-> run_lamp)
    else $error("spin without run lamp");
  a_spin_line: assert property (spin_enable |-> $past(!start_stop_n))
    else $error("spin while start line false");
  a_safe_cond: assert property (safe_lamp |-> $past(sense.power_ok && sense.disk_stopped &&
      sense.heads_retracted && !sense.brake_active))
    else $error("safe with unsafe sense");
  a_lock_safe: assert property (!safe_lamp |-> cart_lock)
    else $error("lock released while unsafe");
  a_allow_wp: assert property (write_allow |-> $past(write_protect_in_n))
    else $error("write allowed under protect input");
  a_settle_cnt: assert property (bus_settled |-> sel_cnt >= 19)
    else $error("settled too early");
  a_deselect: assert property (&unit_select_n |=> !bus_settled && !write_protect_out_oe)
    else $error("outputs kept after deselect");
  a_oe_settled: assert property (write_protect_out_oe |-> bus_settled)
    else $error("driving before settled");
endmodule // dss_checker
`default_nettype wire

// File: bench/dss_ctrl_model.sv
// Behavioural disk controller driving the shared select bus.
`timescale 1ns/1ps
`default_nettype none
module dss_ctrl_model
  import dss_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic [2:0]      unit,
  input  wire logic            wp,
  input  wire logic            plat,
  input  wire logic            spin,
  output logic [NUM_UNITS-1:0] unit_select_n,
  output logic                 write_protect_in_n,
  output logic                 platter_select_n,
  output logic                 start_stop_n,
  output logic                 settled
);
  int         cnt;
  logic [2:0] prev;
  initial begin
    unit_select_n = 4'hf;
    {write_protect_in_n, platter_select_n, start_stop_n, settled} = 4'hf;
    cnt = 0;
    prev = 0;
  end
  always @(posedge aclk) begin
    prev <= unit;
    unit_select_n <= (unit == 0) ? 4'hf : ~(4'h1 << (unit - 1));
    start_stop_n <= !spin;
    write_protect_in_n <= (unit == 0) ? ~write_protect_in_n : !wp;
    platter_select_n <= (unit == 0) ? ~platter_select_n : plat;
    cnt <= (unit == 0 || unit != prev) ? 0 : cnt + 1;
    settled <= (unit != 0) && (cnt >= SETTLE_CYC);
  end
endmodule // dss_ctrl_model
`default_nettype wire

// File: bench/tb_dss_top.sv
// Self-checking testbench of the drive safety and select logic.
`timescale 1ns/1ps
`default_nettype none
module tb_dss_top import dss_pkg::*;;
  logic aclk, aresetn, start_stop_n, write_protect_in_n, platter_select_n, settled;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [RAW_W-1:0] panel_raw;
  dss_sense_t sense, tbl [5];
  logic [UNIT_W-1:0] unit_dial;
  logic [NUM_UNITS-1:0] unit_select_n;
  logic safe_lamp, cart_lock, run_lamp, spin_enable, emergency_unload, head_unload;
  logic write_guard_lamp_upper, write_guard_lamp_lower, write_allow, platter_fixed;
  logic bus_settled, write_protect_out_n_o, write_protect_out_oe, wp, plat, spin, g;
  logic [2:0] unit;
  logic [15:0] rnd;
  int n_errors, n_compared, cyc, m_run;
  dss_top #(.DEB_CYCLES(4)) i_dss_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .panel_raw(panel_raw),
    .sense(sense), .unit_dial(unit_dial), .unit_select_n(unit_select_n),
    .start_stop_n(start_stop_n), .write_protect_in_n(write_protect_in_n),
    .platter_select_n(platter_select_n), .safe_lamp(safe_lamp), .cart_lock(cart_lock),
    .run_lamp(run_lamp), .spin_enable(spin_enable), .emergency_unload(emergency_unload),
    .head_unload(head_unload), .write_guard_lamp_upper(write_guard_lamp_upper),
    .write_guard_lamp_lower(write_guard_lamp_lower), .write_allow(write_allow),
    .platter_fixed(platter_fixed), .bus_settled(bus_settled),
    .write_protect_out_n_o(write_protect_out_n_o),
    .write_protect_out_oe(write_protect_out_oe));
  dss_ctrl_model i_dss_ctrl_model (.aclk(aclk), .unit(unit), .wp(wp), .plat(plat),
    .spin(spin), .unit_select_n(unit_select_n), .write_protect_in_n(write_protect_in_n),
    .platter_select_n(platter_select_n), .start_stop_n(start_stop_n), .settled(settled));
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      stop_test;
    end
  end
  // ****************************************
  // Model and helpers
  // ****************************************
  function logic m_fault(input dss_sense_t s);
    return !s.power_ok | (s.speed_checked & !s.speed_ok) | s.positioner_err | s.write_fault;
  endfunction
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task stop_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    @(posedge aclk);
    {aw, w} = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw = aw | (s_axi_awvalid & s_axi_awready);
      w = w | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, r);
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task axr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask
  task press;
    panel_raw[0] <= 1;
    cy(8);
    panel_raw[0] <= 0;
    cy(8);
    if (m_run == 1) m_run = 2;
    else if (m_run == 0 && panel_raw[3] && !m_fault(sense)) m_run = 1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {panel_raw, unit_dial, unit, wp, plat, spin, aresetn} = 0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_wstrb = 4'hf;
    sense = 10'h3a0;
    tbl = '{10'h1a0, 10'h3b0, 10'h3a4, 10'h3a2, 10'h3b8};
    rnd = 16'ha108;
    {n_errors, n_compared, cyc, m_run} = 0;
    spin = 1;
    cy(6);
    chk(cart_lock, 1);
    aresetn <= 1;
    cy(12);
    chk(safe_lamp, 1);
    chk(cart_lock, 0);
    axr(OFF_CTRL, 0, RESP_OKAY);
    axr(OFF_STATUS, 32'h0000_0011, RESP_OKAY);
    axw(OFF_STATUS, 0, RESP_SLVERR);
    axr(32'h0000_0008, 0, RESP_DECERR);
    axw(32'h0000_000c, 0, RESP_DECERR);
    sense.brake_active <= 1;
    cy(3);
    chk(safe_lamp, 0);
    sense <= 10'h380;
    cy(3);
    chk(safe_lamp, 1);
    axw(OFF_CTRL, 1, RESP_OKAY);
    cy(3);
    chk(safe_lamp, 0);
    sense <= 10'h3a0;
    cy(3);
    chk(safe_lamp, 1);
    press;
    chk(run_lamp, m_run == 1);
    panel_raw[3] <= 1;
    cy(10);
    press;
    chk(run_lamp, m_run == 1);
    chk(spin_enable, 1);
    sense <= 10'h220;
    cy(3);
    chk(cart_lock, 1);
    press;
    chk(run_lamp, m_run == 1);
    chk(head_unload, 1);
    sense <= 10'h3a0;
    m_run = 0;
    cy(4);
    chk(safe_lamp, 1);
    press;
    sense <= 10'h020;
    m_run = 0;
    cy(3);
    chk(emergency_unload, 1);
    chk(head_unload, 1);
    chk(run_lamp, m_run == 1);
    sense <= 10'h3a0;
    cy(3);
    chk(run_lamp, 0);
    for (int i = 0; i < 5; i++) begin
      sense <= tbl[i];
      cy(3);
      chk(emergency_unload, m_fault(tbl[i]));
    end
    sense <= 10'h3a0;
    unit <= 1;
    do cy(1); while (settled !== 1'b1);
    cy(2);
    chk(bus_settled, 1);
    repeat (8) begin
      rnd = lfsr(rnd);
      panel_raw[2:1] <= rnd[1:0];
      {plat, wp} <= rnd[3:2];
      cy(12);
      chk(write_guard_lamp_upper, rnd[0]);
      chk(write_guard_lamp_lower, rnd[1]);
      chk(platter_fixed, !rnd[3]);
      chk(write_allow, !rnd[2] && !(rnd[3] ? rnd[0] : rnd[1]));
      chk(write_protect_out_n_o, !(rnd[3] ? rnd[0] : rnd[1]));
      chk(write_protect_out_oe, 1);
    end
    g = rnd[0];
    sense.write_active <= 1;
    panel_raw[1] <= !g;
    cy(12);
    chk(write_guard_lamp_upper, g);
    sense.write_active <= 0;
    cy(3);
    chk(write_guard_lamp_upper, !g);
    unit <= 2;
    cy(25);
    chk(bus_settled, 0);
    chk(write_allow, 0);
    axw(OFF_CTRL, 2, RESP_OKAY);
    unit_dial <= 2;
    unit <= 3;
    cy(25);
    chk(bus_settled, 1);
    chk(write_protect_out_oe, 1);
    unit <= 0;
    cy(3);
    chk(write_protect_out_oe, 0);
    press;
    chk(spin_enable, 1);
    spin <= 0;
    cy(3);
    chk(spin_enable, 0);
    sense <= 10'h221;
    cy(3);
    press;
    chk(head_unload, 0);
    sense.write_active <= 0;
    cy(3);
    chk(head_unload, 1);
    stop_test;
  end
endmodule // tb_dss_top
bind dss_top dss_checker i_dss_checker (.aclk(aclk), .aresetn(aresetn), .sense(sense),
  .unit_select_n(unit_select_n), .start_stop_n(start_stop_n),
  .write_protect_in_n(write_protect_in_n), .safe_lamp(safe_lamp), .cart_lock(cart_lock),
  .run_lamp(run_lamp), .spin_enable(spin_enable), .emergency_unload(emergency_unload),
  .head_unload(head_unload), .write_allow(write_allow), .bus_settled(bus_settled),
  .write_protect_out_oe(write_protect_out_oe));
`default_nettype wire
